/* File: core/dspmac_top.sv */
// Purpose: configurable multiply, multiply-accumulate and add/sub datapath
// Assumes: fabric drives operands and controls on clk_i
// Notes: result appears three edges after the operand edge
`timescale 1ns/10ps
module dspmac_top #(
    parameter int ACC_W = dspmac_pkg::ACC_W
) (
    input  wire logic                        clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic [dspmac_pkg::OP_W-1:0] op_a_i,
    input  wire logic [dspmac_pkg::OP_W-1:0] op_b_i,
    input  wire logic                        op_valid_i,
    input  wire dspmac_pkg::dspmac_dyn_t     dyn_i,
    input  wire logic [dspmac_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [31:0]                 reg_wdata_i,
    input  wire logic                        reg_wr_i,
    input  wire logic                        reg_rd_i,
    output logic      [31:0]                 reg_rdata_o,
    output logic      [dspmac_pkg::RES_W-1:0] result_o,
    output logic                             result_valid_o
);

    localparam int LW = dspmac_pkg::LANE_W;
    localparam int NL = dspmac_pkg::LANES;
    localparam int SW = dspmac_pkg::SLOT_W;
    localparam int OW = dspmac_pkg::OP_W;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_q1;
    logic rst_n;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end
        else
        begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    dspmac_pkg::dspmac_cfg_t cfg;
    logic                    acc_clr;
    logic [3:0]              elems;
    logic                    cfg_bad;

    wire logic wr_ctrl = reg_wr_i && (reg_addr_i == dspmac_pkg::ADDR_CTRL);
    wire logic rd_ctrl = reg_rd_i && (reg_addr_i == dspmac_pkg::ADDR_CTRL);
    wire logic rd_stat = reg_rd_i && (reg_addr_i == dspmac_pkg::ADDR_STATUS);

    assign elems   = dspmac_pkg::elem_count(cfg.mode, cfg.width);
    assign cfg_bad = (elems == 4'h0);

    wire logic [31:0] stat_word = 32'({result_valid_o, cfg_bad, elems});
    wire logic [31:0] next_rdata = rd_ctrl ? 32'(cfg) : rd_stat ? stat_word : 32'h0;

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg         <= dspmac_pkg::CTRL_RESET;
            acc_clr     <= 1'b0;
            reg_rdata_o <= 32'h0;
        end
        else
        begin
            if (wr_ctrl)
                cfg <= dspmac_pkg::dspmac_cfg_t'(reg_wdata_i[7:0]);
            acc_clr     <= wr_ctrl && reg_wdata_i[dspmac_pkg::CTRL_CLR_BIT];
            reg_rdata_o <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // control select and operand registers
    // ----------------------------------------------------------------
    dspmac_pkg::dspmac_dyn_t ctl;
    assign ctl = cfg.dyn ? dyn_i : cfg.stat;

    // lanes per element for x9 and x18, all 8 lanes for x36: shift step for the chain
    wire logic [3:0] step = (cfg.width == dspmac_pkg::width_x9)  ? 4'h1 :
                            (cfg.width == dspmac_pkg::width_x18) ? 4'h2 : 4'(NL);

    logic [OW-1:0] a_q;
    logic [OW-1:0] b_q;

    for (genvar i = 0; i < NL; i++)
    begin : g_lane
        wire logic [LW-1:0] src_a = (i < step) ? op_a_i[i*LW +: LW]
                                               : a_q[(i-step)*LW +: LW];
        wire logic [LW-1:0] src_b = (i < step) ? op_b_i[i*LW +: LW]
                                               : b_q[(i-step)*LW +: LW];
        dspmac_lane #(.W(LW)) u_lane (
            .clk_i        (clk_i),
            .rst_n_i      (rst_n),
            .par_a_i      (op_a_i[i*LW +: LW]),
            .par_b_i      (op_b_i[i*LW +: LW]),
            .shf_a_i      (src_a),
            .shf_b_i      (src_b),
            .load_shift_i (ctl.load_shift),
            .a_o          (a_q[i*LW +: LW]),
            .b_o          (b_q[i*LW +: LW])
        );
    end

    // controls captured with the operands
    dspmac_pkg::dspmac_dyn_t ctl1;
    dspmac_pkg::dspmac_dyn_t ctl2;
    logic                    vld1;
    logic                    vld2;

    // ----------------------------------------------------------------
    // multipliers
    // ----------------------------------------------------------------
    logic [dspmac_pkg::RES_W-1:0] next_prod;
    logic [dspmac_pkg::RES_W-1:0] prod;
    wire logic [dspmac_pkg::RES_W-1:0] prod9;
    wire logic [dspmac_pkg::RES_W-1:0] prod18;

    for (genvar k = 0; k < NL; k++)
    begin : g_m9
        wire logic signed [LW:0] xa = {ctl1.sgn & a_q[k*LW+LW-1], a_q[k*LW +: LW]};
        wire logic signed [LW:0] xb = {ctl1.sgn & b_q[k*LW+LW-1], b_q[k*LW +: LW]};
        wire logic signed [2*LW+1:0] p = xa * xb;
        assign prod9[k*2*LW +: 2*LW] = p[2*LW-1:0];
    end
    for (genvar k = 0; k < NL/2; k++)
    begin : g_m18
        wire logic [2*LW-1:0] ua = a_q[k*2*LW +: 2*LW];
        wire logic [2*LW-1:0] ub = b_q[k*2*LW +: 2*LW];
        wire logic signed [2*LW:0] xa = {ctl1.sgn & ua[2*LW-1], ua};
        wire logic signed [2*LW:0] xb = {ctl1.sgn & ub[2*LW-1], ub};
        wire logic signed [4*LW+1:0] p = xa * xb;
        assign prod18[k*4*LW +: 4*LW] = p[4*LW-1:0];
    end

    wire logic signed [OW/2:0] xa36 = {ctl1.sgn & a_q[OW/2-1], a_q[OW/2-1:0]};
    wire logic signed [OW/2:0] xb36 = {ctl1.sgn & b_q[OW/2-1], b_q[OW/2-1:0]};
    wire logic signed [OW+1:0] p36  = xa36 * xb36;

    always_comb
    begin
        next_prod = '0;
        case (cfg.width)
            dspmac_pkg::width_x9:
                next_prod = prod9;
            dspmac_pkg::width_x18:
                next_prod = prod18;
            dspmac_pkg::width_x36:
                next_prod[OW-1:0] = p36[OW-1:0];
            default:
                next_prod = '0;
        endcase
    end

    // ----------------------------------------------------------------
    // pipeline registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl1 <= '0;
            ctl2 <= '0;
            vld1 <= 1'b0;
            vld2 <= 1'b0;
            prod <= '0;
        end
        else
        begin
            ctl1 <= ctl;
            vld1 <= op_valid_i;
            ctl2 <= ctl1;
            vld2 <= vld1;
            prod <= next_prod;
        end
    end

    // ----------------------------------------------------------------
    // product extension, add/sub pairs and sums
    // ----------------------------------------------------------------
    logic signed [ACC_W-1:0] e9   [NL];
    logic signed [ACC_W-1:0] e18  [NL/2];
    logic signed [ACC_W-1:0] pr9  [NL/2];
    logic signed [ACC_W-1:0] pr18 [2];
    logic signed [ACC_W-1:0] sm9  [2];
    logic signed [ACC_W-1:0] sm18;

    always_comb
    begin
        for (int k = 0; k < NL; k++)
            e9[k] = ACC_W'($signed({ctl2.sgn & prod[k*2*LW+2*LW-1], prod[k*2*LW +: 2*LW]}));
        for (int k = 0; k < NL/2; k++)
            e18[k] = ACC_W'($signed({ctl2.sgn & prod[k*4*LW+4*LW-1], prod[k*4*LW +: 4*LW]}));
        for (int k = 0; k < NL/2; k++)
            pr9[k] = ctl2.sub ? e9[2*k] - e9[2*k+1] : e9[2*k] + e9[2*k+1];
        for (int k = 0; k < 2; k++)
            pr18[k] = ctl2.sub ? e18[2*k] - e18[2*k+1] : e18[2*k] + e18[2*k+1];
        for (int k = 0; k < 2; k++)
            sm9[k] = pr9[2*k] + pr9[2*k+1];
        sm18 = pr18[0] + pr18[1];
    end

    // ----------------------------------------------------------------
    // accumulators
    // ----------------------------------------------------------------
    logic signed [ACC_W-1:0] acc      [2];
    logic signed [ACC_W-1:0] acc_in   [2];
    logic signed [ACC_W-1:0] next_acc [2];

    wire logic is_x9   = (cfg.width == dspmac_pkg::width_x9);
    wire logic is_mac  = (cfg.mode == dspmac_pkg::multiply_accumulate_mode);
    wire logic is_sacc = (cfg.mode == dspmac_pkg::multiply_addsub_accumulate_mode);
    wire logic acc_go  = vld2 && !cfg_bad && (is_mac || is_sacc);

    always_comb
    begin
        for (int k = 0; k < 2; k++)
        begin
            if (is_mac)
                acc_in[k] = is_x9 ? e9[k] : e18[k];
            else
                acc_in[k] = is_x9 ? sm9[k] : ((k == 0) ? sm18 : '0);
            if (acc_clr)
                next_acc[k] = '0;
            else if (acc_go)
                next_acc[k] = ctl2.sub ? acc[k] - acc_in[k] : acc[k] + acc_in[k];
            else
                next_acc[k] = acc[k];
        end
    end

    // ----------------------------------------------------------------
    // result packing
    // ----------------------------------------------------------------
    logic [dspmac_pkg::RES_W-1:0] next_res;

    always_comb
    begin
        next_res = '0;
        if (!cfg_bad)
        begin
            case (cfg.mode)
                dspmac_pkg::plain_multiply_mode:
                    next_res = prod;
                dspmac_pkg::multiply_addsub_mode:
                    if (is_x9)
                        for (int k = 0; k < NL/2; k++)
                            next_res[k*SW +: SW] = SW'(pr9[k]);
                    else
                        for (int k = 0; k < 2; k++)
                            next_res[k*OW +: OW] = OW'(pr18[k]);
                default:
                    for (int k = 0; k < 2; k++)
                        next_res[k*OW +: OW] = OW'(next_acc[k]);
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc[0]         <= '0;
            acc[1]         <= '0;
            result_o       <= '0;
            result_valid_o <= 1'b0;
        end
        else
        begin
            acc[0]         <= next_acc[0];
            acc[1]         <= next_acc[1];
            result_o       <= next_res;
            result_valid_o <= vld2 && !cfg_bad;
        end
    end

endmodule // dspmac_top

/* File: core/dspmac_pkg.sv */
// Purpose: constants and types of the multiply-accumulate datapath block
// Assumes: one clock, operands and controls from fabric logic on that clock
// Notes: Function list below
package dspmac_pkg;

    // ----------------------------------------------------------------
    // datapath geometry
    // ----------------------------------------------------------------
    localparam int LANE_W  = 9;
    localparam int LANES   = 8;
    localparam int OP_W    = LANE_W * LANES;
    localparam int RES_W   = 2 * OP_W;
    localparam int SLOT_W  = OP_W / 2;
    localparam int ACC_W   = 52;
    localparam int LAT     = 3;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int         ADDR_W         = 4;
    localparam logic [3:0] ADDR_CTRL      = 4'h0;
    localparam logic [3:0] ADDR_STATUS    = 4'h4;
    localparam int         CTRL_CLR_BIT   = 8;
    localparam int         STAT_CNT_LSB   = 0;
    localparam int         STAT_BAD_BIT   = 4;
    localparam int         STAT_VALID_BIT = 5;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        plain_multiply_mode             = 2'h0,
        multiply_accumulate_mode        = 2'h1,
        multiply_addsub_accumulate_mode = 2'h2,
        multiply_addsub_mode            = 2'h3
    } dspmac_mode_t;

    typedef enum logic [1:0] {
        width_x9  = 2'h0,
        width_x18 = 2'h1,
        width_x36 = 2'h2,
        width_bad = 2'h3
    } dspmac_width_t;

    typedef struct packed {
        logic load_shift;
        logic sub;
        logic sgn;
    } dspmac_dyn_t;

    typedef struct packed {
        dspmac_dyn_t   stat;
        logic          dyn;
        dspmac_width_t width;
        dspmac_mode_t  mode;
    } dspmac_cfg_t;

    localparam dspmac_cfg_t CTRL_RESET = dspmac_cfg_t'(8'h00);

    // elements available per mode and width, zero where unavailable
    function automatic logic [3:0] elem_count(dspmac_mode_t m, dspmac_width_t w);
        logic [3:0] n;
        n = 4'h0;
        case (m)
            plain_multiply_mode:
                n = (w == width_x9) ? 4'h8 : (w == width_x18) ? 4'h4 :
                    (w == width_x36) ? 4'h1 : 4'h0;
            multiply_accumulate_mode:
                n = (w == width_x9 || w == width_x18) ? 4'h2 : 4'h0;
            multiply_addsub_mode:
                n = (w == width_x9) ? 4'h4 : (w == width_x18) ? 4'h2 : 4'h0;
            multiply_addsub_accumulate_mode:
                n = (w == width_x9) ? 4'h2 : (w == width_x18) ? 4'h1 : 4'h0;
            default:
                n = 4'h0;
        endcase
        return n;
    endfunction

endpackage

/* File: core/dspmac_lane.sv */
// Purpose: one 9-bit operand lane, register pair for A and B
// Assumes: shift source is the preceding element's register
// Notes: lanes of one wide element shift together
`timescale 1ns/10ps
module dspmac_lane #(
    parameter int W = 9
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] par_a_i,
    input  wire logic [W-1:0] par_b_i,
    input  wire logic [W-1:0] shf_a_i,
    input  wire logic [W-1:0] shf_b_i,
    input  wire logic         load_shift_i,
    output logic      [W-1:0] a_o,
    output logic      [W-1:0] b_o
);

    // ----------------------------------------------------------------
    // load select
    // ----------------------------------------------------------------
    wire logic [W-1:0] next_a = load_shift_i ? shf_a_i : par_a_i;
    wire logic [W-1:0] next_b = load_shift_i ? shf_b_i : par_b_i;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            a_o <= '0;
            b_o <= '0;
        end
        else
        begin
            a_o <= next_a;
            b_o <= next_b;
        end
    end

endmodule // dspmac_lane

/* File: tb/dspmac_properties.sv */
// Purpose: port-level checks of the multiply-accumulate block
// Assumes: config is rewritten only while no operand set is in flight
// Notes: CTRL is shadowed from register writes
`timescale 1ns/10ps
module dspmac_properties #(
    parameter int ACC_W = 52
) (
    input wire logic                          clk_i,
    input wire logic                          rst_n_i,
    input wire logic [dspmac_pkg::OP_W-1:0]   op_a_i,
    input wire logic [dspmac_pkg::OP_W-1:0]   op_b_i,
    input wire logic                          op_valid_i,
    input wire dspmac_pkg::dspmac_dyn_t       dyn_i,
    input wire logic [dspmac_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0]                   reg_wdata_i,
    input wire logic                          reg_wr_i,
    input wire logic                          reg_rd_i,
    input wire logic [31:0]                   reg_rdata_o,
    input wire logic [dspmac_pkg::RES_W-1:0]  result_o,
    input wire logic                          result_valid_o
);
    // ----
    // helper logic
    // ----
    logic [7:0] cfg;
    logic [8:0] prev_a0;
    logic [8:0] prev_b0;
    function automatic logic [17:0] mul9(logic [8:0] a, logic [8:0] b, logic s);
        logic [17:0] ea;
        logic [17:0] eb;
        ea = {{9{s & a[8]}}, a};
        eb = {{9{s & b[8]}}, b};
        return ea * eb;
    endfunction
    wire logic        x9_plain = (cfg[3:0] == 4'h0);
    wire logic        eff_sgn  = cfg[4] ? dyn_i.sgn : cfg[5];
    wire logic        eff_ld   = cfg[4] ? dyn_i.load_shift : cfg[7];
    wire logic [17:0] p_own    = mul9(op_a_i[8:0], op_b_i[8:0], eff_sgn);
    wire logic [17:0] p_shf    = mul9(prev_a0, prev_b0, eff_sgn);
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cfg     <= 8'h00;
            prev_a0 <= 9'h000;
            prev_b0 <= 9'h000;
        end
        else
        begin
            if (reg_wr_i && reg_addr_i == dspmac_pkg::ADDR_CTRL)
                cfg <= reg_wdata_i[7:0];
            prev_a0 <= op_a_i[8:0];
            prev_b0 <= op_b_i[8:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ----
    // assertions
    // ----
    a_read_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property ($past(reg_rd_i) && $past(reg_addr_i) != 4'h0
        && $past(reg_addr_i) != 4'h4 |-> reg_rdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_ctrl_readback: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 4'h0
        |-> reg_rdata_o == {24'h0, $past(cfg)})
        else $error("control readback wrong");
    a_valid_has_cause: assert property (result_valid_o |-> $past(op_valid_i, 3))
        else $error("result valid without operand");
    a_idle_no_valid: assert property (!op_valid_i |-> ##3 !result_valid_o)
        else $error("result valid after idle cycle");
    a_plain_valid: assert property (op_valid_i && x9_plain |-> ##3 result_valid_o)
        else $error("plain result not valid");
    a_lane0_product: assert property (op_valid_i && x9_plain
        |-> ##3 result_o[17:0] == $past(p_own, 3))
        else $error("lane 0 product wrong");
    a_shift_lane1: assert property (op_valid_i && x9_plain && eff_ld
        |-> ##3 result_o[35:18] == $past(p_shf, 3))
        else $error("shifted lane 1 product wrong");
endmodule // dspmac_properties
bind dspmac_top dspmac_properties #(.ACC_W(ACC_W)) u_props (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .op_a_i(op_a_i), .op_b_i(op_b_i),
    .op_valid_i(op_valid_i), .dyn_i(dyn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .result_o(result_o), .result_valid_o(result_valid_o)
);

/* File: tb/dspmac_fabric.sv */
// Purpose: fabric logic feeding operands and dynamic controls
// Assumes: one operand set per cycle
// Notes: idle cycles scramble the operand lines
`timescale 1ns/10ps
module dspmac_fabric (
    input  wire logic                        clk_i,
    output logic [dspmac_pkg::OP_W-1:0]      op_a_o,
    output logic [dspmac_pkg::OP_W-1:0]      op_b_o,
    output logic                             valid_o,
    output dspmac_pkg::dspmac_dyn_t          dyn_o
);
    initial
    begin
        op_a_o  = '0;
        op_b_o  = '0;
        valid_o = 1'b0;
        dyn_o   = '0;
    end
    task automatic send(input logic [71:0] a, input logic [71:0] b, input logic [2:0] d);
        @(posedge clk_i);
        op_a_o  <= a;
        op_b_o  <= b;
        valid_o <= 1'b1;
        dyn_o   <= d;
    endtask
    task automatic idle();
        @(posedge clk_i);
        op_a_o  <= ~op_a_o;
        op_b_o  <= ~op_b_o;
        valid_o <= 1'b0;
        dyn_o   <= ~dyn_o;
    endtask
endmodule // dspmac_fabric

/* File: tb/testbench.sv */
// Purpose: self-checking bench of the multiply-accumulate block
// Assumes: config written only while the datapath is idle
// Notes: results checked three edges after the operand edge
`timescale 1ns/10ps
module testbench;
    logic         clk       = 1'b0;
    logic         rst_n     = 1'b0;
    logic [3:0]   reg_addr  = 4'h0;
    logic [31:0]  reg_wdata = 32'h0;
    logic         reg_wr    = 1'b0;
    logic         reg_rd    = 1'b0;
    logic [31:0]  reg_rdata;
    logic [143:0] result;
    logic         result_valid;
    logic [71:0]  op_a;
    logic [71:0]  op_b;
    logic         op_valid;
    dspmac_pkg::dspmac_dyn_t dyn;
    int           n_errors = 0;
    int           samples_checked = 0;
    always #5 clk = ~clk;
    dspmac_fabric fab (.clk_i(clk), .op_a_o(op_a), .op_b_o(op_b), .valid_o(op_valid),
        .dyn_o(dyn));
    dspmac_top dut (.clk_i(clk), .rst_n_i(rst_n), .op_a_i(op_a), .op_b_i(op_b),
        .op_valid_i(op_valid), .dyn_i(dyn), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .result_o(result),
        .result_valid_o(result_valid));
    // ----
    // shared tasks
    // ----
    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [144:0] got, input logic [144:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic settle();
        @(posedge clk);
        #1;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_counts();
        logic [63:0] tbl;
        logic [31:0] d;
        logic [3:0]  n;
        tbl = 64'h0000000121244228;
        reg_read(4'h0, d);
        chk(d, 32'h0);
        reg_read(4'h8, d);
        chk(d, 32'h0);
        for (int i = 0; i < 16; i++)
        begin
            reg_write(4'h0, 32'(i));
            reg_read(4'h0, d);
            chk(d, 32'(i));
            reg_read(4'h4, d);
            n = tbl[4*i +: 4];
            chk(d, {27'h0, (n == 4'h0), n});
        end
        fab.send('1, '1, 3'h0);
        fab.idle();
        repeat (2) settle();
        chk({result_valid, result}, 145'h0);
    endtask
    task automatic t_signed();
        reg_write(4'h0, 32'h10);
        fab.send({9'h002, 54'h0, 9'h1FF}, {9'h002, 54'h0, 9'h003}, 3'h1);
        fab.send({9'h002, 54'h0, 9'h1FF}, {9'h002, 54'h0, 9'h003}, 3'h0);
        fab.idle();
        settle();
        chk({result_valid, result[143:126], result[17:0]}, {1'b1, 18'h4, 18'h3FFFD});
        settle();
        chk(result[17:0], 18'h005FD);
    endtask
    task automatic t_shift();
        logic [71:0] a1;
        logic [71:0] ones;
        for (int k = 0; k < 8; k++)
        begin
            a1[9*k +: 9]   = 9'(k + 1);
            ones[9*k +: 9] = 9'h001;
        end
        reg_write(4'h0, 32'h10);
        fab.send(a1, ones, 3'h0);
        fab.send(72'h00A, 72'h001, 3'h4);
        fab.idle();
        settle();
        for (int k = 0; k < 8; k++)
            chk(result[18*k +: 18], 18'(k + 1));
        settle();
        for (int k = 0; k < 8; k++)
            chk(result[18*k +: 18], (k == 0) ? 18'hA : 18'(k));
    endtask
    task automatic t_mac();
        reg_write(4'h0, 32'h115);
        fab.send(72'h3, 72'h5, 3'h0);
        fab.send(72'h2, 72'h4, 3'h2);
        fab.idle();
        settle();
        chk(result, 144'hF);
        settle();
        chk(result, 144'h7);
    endtask
    task automatic t_widths();
        reg_write(4'h0, 32'h18);
        fab.send({36'h123, 36'hFFFFFFFFF}, 72'h2, 3'h1);
        fab.idle();
        repeat (2) settle();
        chk({result_valid, result}, {1'b1, 72'h0, ~72'h1});
        reg_write(4'h0, 32'h43);
        fab.send({54'h0, 9'h003, 9'h007}, {8{9'h001}}, 3'h4);
        fab.send({54'h0, 9'h007, 9'h003}, {8{9'h001}}, 3'h4);
        fab.idle();
        settle();
        chk(result, 144'h4);
        settle();
        chk(result, {108'h0, ~36'h3});
        reg_write(4'h0, 32'h116);
        fab.send({36'h0, 18'h2, 18'h5}, {36'h0, 18'h1, 18'h1}, 3'h0);
        fab.send({36'h0, 18'h2, 18'h5}, {36'h0, 18'h1, 18'h1}, 3'h2);
        fab.idle();
        settle();
        chk({result_valid, result}, {1'b1, 144'h7});
        settle();
        chk(result, 144'h4);
    endtask
    initial
    begin
        #500000;
        n_errors++;
        print_verdict();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_counts();
        t_signed();
        t_shift();
        t_mac();
        t_widths();
        repeat (4) @(posedge clk);
        print_verdict();
    end
endmodule // testbench
